// File: irs_defs.svh
// What this block does
// - Receive path has a six-bit divider on the system clock timing pulses
// - Pulses of legal width are accepted for system clocks of 5 to 50 MHz
// - Divider upper four bits come from the factor field, lower two are 3
// - Factor zero skips pulse qualification; receiver then decodes by edge detection
// - After the first bit every decoded bit is exactly 16 baud clocks wide
// - Loopback bit inverts the transmit output and feeds it to receive
// - External loopback works by transmitting with receive enabled
// - Control resets to zero; unused bits ignore writes and read zero
// - Receive enable clear ignores input; set routes decoded data to UART
// - Codec enable bit turns the encoder and decoder off or on
// - Zero bit sends 7 low, 3 high, 6 low clocks; one bit stays low
// - Full duplex: the encoder keeps transmitting while decoding is enabled
`ifndef IRS_DEFS_SVH
`define IRS_DEFS_SVH
`define IRS_CTL_IDX 10'h0bf
`define IRS_STAT_IDX 10'h0c0
`define IRS_CTL_RST 8'h00
`define IRS_CTL_MASK 8'hf7
`define IRS_DIV_LOW 2'b11
`define IRS_BIT_TICKS 5'h10
`define IRS_PULSE_FIRST 4'h7
`define IRS_PULSE_LAST 4'h9
`define IRS_OVF_BIT 3
`define IRS_RESP_OKAY 2'b00
`define IRS_RESP_SLVERR 2'b10
`endif

// File: irs_pkg.sv
package irs_pkg;
    // Decoder states, Gray along idle, measure, qualified
    typedef enum logic [1:0] {
        IRS_IDLE = 2'b00,
        IRS_MEAS = 2'b01,
        IRS_QUAL = 2'b11
    } irs_dec_e;
    // Control register layout
    typedef struct packed {
        logic [3:0] div;
        logic rsvd;
        logic loop;
        logic rxen;
        logic en;
    } irs_ctl_s;
endpackage

// File: irs_endec.sv
`timescale 1ns/1ps
`include "irs_defs.svh"
module irs_endec import irs_pkg::*; #(
    parameter int PW_W = 8
) (
    input wire logic aclk, // System clock
    input wire logic aresetn, // Sync reset, low
    input wire logic ce, // Clock enable
    input wire logic baud_tick, // 16x baud pulse
    input wire logic uart_txd, // UART transmit data
    output logic uart_rxd, // To UART receive
    input wire logic infrared_receive_in, // From transceiver
    output logic infrared_transmit_out, // To transceiver
    output logic pw_valid, // Pulse word valid
    output logic [PW_W-1:0] pw_data, // Pulse width
    input wire logic pw_ready, // Pulse word taken
    input wire logic [11:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write addr valid
    output logic s_axi_awready, // Write addr ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Response valid
    input wire logic s_axi_bready, // Response ready
    input wire logic [11:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read addr valid
    output logic s_axi_arready, // Read addr ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read valid
    input wire logic s_axi_rready // Read ready
);
    if (PW_W < 2) begin : g_chk
        $error("PW_W must be at least 2");
    end

    // Word index of a byte address
    function automatic logic [9:0] word_idx(input logic [11:0] a);
        return a[11:2];
    endfunction

    // Register state
    irs_ctl_s ctl_q, ctl_d;
    logic ovf_q, ovf_d;
    logic aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [9:0] wr_idx_q, wr_idx_d;
    logic [7:0] wr_data_q, wr_data_d;
    logic wr_strb_q, wr_strb_d;
    logic bvalid_d, arready_d, rvalid_d;
    logic [1:0] bresp_d, rresp_d;
    logic [31:0] rdata_d;
    // Encoder state
    logic txd_prev_q, txd_prev_d, tx_bit_q, tx_bit_d;
    logic [3:0] phase_q, phase_d;
    logic tx_out_d;
    // Decoder state
    irs_dec_e st_q, st_d;
    logic [5:0] div_cnt_q, div_cnt_d;
    logic [PW_W-1:0] width_q, width_d;
    logic [4:0] hold_q, hold_d;
    logic rxd_d;
    logic push;
    logic [PW_W-1:0] push_word;
    // Buffer state
    logic tail_v_q, tail_v_d;
    logic [PW_W-1:0] tail_q, tail_d;
    logic head_v_d;
    logic [PW_W-1:0] head_d;

    // Shared terms
    logic active, rx_low, div_hit;
    logic [5:0] div_top;
    always_comb begin
        active = ctl_q.en && ctl_q.rxen;
        // Internal loopback: inverted transmit into receive
        rx_low = ctl_q.loop ? infrared_transmit_out
                            : !infrared_receive_in;
        div_top = {ctl_q.div, `IRS_DIV_LOW};
        div_hit = (div_cnt_q == div_top);
    end

    // Bus slave: takes address and data in either order
    always_comb begin
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        wr_idx_d = wr_idx_q;
        wr_data_d = wr_data_q;
        wr_strb_d = wr_strb_q;
        bvalid_d = s_axi_bvalid;
        bresp_d = s_axi_bresp;
        ctl_d = ctl_q;
        ovf_d = ovf_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_have_d = 1'b1;
            wr_idx_d = word_idx(s_axi_awaddr);
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_have_d = 1'b1;
            wr_data_d = s_axi_wdata[7:0];
            wr_strb_d = s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (aw_have_q && w_have_q && !s_axi_bvalid) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = `IRS_RESP_OKAY;
            if (wr_idx_q == `IRS_CTL_IDX) begin
                if (wr_strb_q) begin
                    ctl_d = wr_data_q & `IRS_CTL_MASK;
                end
            end else if (wr_idx_q == `IRS_STAT_IDX) begin
                if (wr_strb_q && wr_data_q[`IRS_OVF_BIT]) begin
                    ovf_d = 1'b0;
                end
            end else begin
                bresp_d = `IRS_RESP_SLVERR;
            end
        end
        // A refused pulse word sets overflow over any clear
        if (push && tail_v_q && !(pw_valid && pw_ready)) begin
            ovf_d = 1'b1;
        end
    end

    // Read channel
    always_comb begin
        arready_d = s_axi_arready;
        rvalid_d = s_axi_rvalid;
        rdata_d = s_axi_rdata;
        rresp_d = s_axi_rresp;
        if (s_axi_rvalid && s_axi_rready) begin
            rvalid_d = 1'b0;
            arready_d = 1'b1;
        end else if (!s_axi_rvalid) begin
            arready_d = 1'b1;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            arready_d = 1'b0;
            rvalid_d = 1'b1;
            rresp_d = `IRS_RESP_OKAY;
            rdata_d = '0;
            if (word_idx(s_axi_araddr) == `IRS_CTL_IDX) begin
                rdata_d[7:0] = ctl_q;
            end else if (word_idx(s_axi_araddr) == `IRS_STAT_IDX) begin
                rdata_d[5:0] = {st_q, ovf_q, tx_bit_q,
                                infrared_transmit_out, uart_rxd};
            end else begin
                rresp_d = `IRS_RESP_SLVERR;
            end
        end
    end

    // Encoder: 16 ticks per bit, realigned on each TxD edge
    always_comb begin
        txd_prev_d = uart_txd;
        tx_bit_d = tx_bit_q;
        phase_d = phase_q;
        if (uart_txd != txd_prev_q) begin
            phase_d = '0;
            tx_bit_d = uart_txd;
        end else if (baud_tick) begin
            phase_d = phase_q + 4'h1;
        end
        // Zero bit: pulse high in ticks 7 to 9 only
        tx_out_d = ctl_q.en && !tx_bit_d
                   && phase_d >= `IRS_PULSE_FIRST
                   && phase_d <= `IRS_PULSE_LAST;
    end

    // Decoder: pulse width measured in divider periods
    always_comb begin
        st_d = st_q;
        div_cnt_d = div_cnt_q;
        width_d = width_q;
        hold_d = hold_q;
        push = 1'b0;
        push_word = width_q;
        if (baud_tick && hold_q != '0) begin
            hold_d = hold_q - 5'h01;
        end
        unique case (st_q)
            IRS_IDLE: begin
                div_cnt_d = '0;
                width_d = '0;
                if (rx_low && active) begin
                    if (ctl_q.div == '0) begin
                        st_d = IRS_QUAL;
                        hold_d = `IRS_BIT_TICKS;
                    end else begin
                        st_d = IRS_MEAS;
                    end
                end
            end
            IRS_MEAS: begin
                div_cnt_d = div_cnt_q + 6'h01;
                if (!rx_low) begin
                    st_d = IRS_IDLE;
                end else if (div_hit) begin
                    // Held for one divider period: legal pulse
                    st_d = IRS_QUAL;
                    div_cnt_d = '0;
                    width_d = {{(PW_W-1){1'b0}}, 1'b1};
                    hold_d = `IRS_BIT_TICKS;
                end
            end
            IRS_QUAL: begin
                div_cnt_d = div_hit ? 6'h00 : div_cnt_q + 6'h01;
                if (div_hit && !(&width_q)) begin
                    width_d = width_q + {{(PW_W-1){1'b0}}, 1'b1};
                end
                if (!rx_low) begin
                    st_d = IRS_IDLE;
                    push = 1'b1;
                end
            end
            default: begin
                st_d = IRS_IDLE;
            end
        endcase
        if (!active) begin
            st_d = IRS_IDLE;
            hold_d = '0;
            push = 1'b0;
        end
        rxd_d = (hold_d == '0);
    end

    // Two-entry pulse word buffer
    always_comb begin
        head_v_d = pw_valid;
        head_d = pw_data;
        tail_v_d = tail_v_q;
        tail_d = tail_q;
        if (pw_valid && pw_ready) begin
            head_v_d = tail_v_q;
            head_d = tail_q;
            tail_v_d = 1'b0;
        end
        // A pop in the same cycle frees the tail for the new word
        if (push && !tail_v_d) begin
            if (!head_v_d) begin
                head_v_d = 1'b1;
                head_d = push_word;
            end else begin
                tail_v_d = 1'b1;
                tail_d = push_word;
            end
        end
    end

    // All state registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl_q <= `IRS_CTL_RST;
            ovf_q <= 1'b0;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            wr_idx_q <= '0;
            wr_data_q <= '0;
            wr_strb_q <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `IRS_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `IRS_RESP_OKAY;
            txd_prev_q <= 1'b1;
            tx_bit_q <= 1'b1;
            phase_q <= '0;
            infrared_transmit_out <= 1'b0;
            st_q <= IRS_IDLE;
            div_cnt_q <= '0;
            width_q <= '0;
            hold_q <= '0;
            uart_rxd <= 1'b1;
            pw_valid <= 1'b0;
            pw_data <= '0;
            tail_v_q <= 1'b0;
            tail_q <= '0;
        end else if (ce) begin
            ctl_q <= ctl_d;
            ovf_q <= ovf_d;
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            wr_idx_q <= wr_idx_d;
            wr_data_q <= wr_data_d;
            wr_strb_q <= wr_strb_d;
            s_axi_awready <= !aw_have_d && !bvalid_d;
            s_axi_wready <= !w_have_d && !bvalid_d;
            s_axi_bvalid <= bvalid_d;
            s_axi_bresp <= bresp_d;
            s_axi_arready <= arready_d;
            s_axi_rvalid <= rvalid_d;
            s_axi_rdata <= rdata_d;
            s_axi_rresp <= rresp_d;
            txd_prev_q <= txd_prev_d;
            tx_bit_q <= tx_bit_d;
            phase_q <= phase_d;
            infrared_transmit_out <= tx_out_d;
            st_q <= st_d;
            div_cnt_q <= div_cnt_d;
            width_q <= width_d;
            hold_q <= hold_d;
            uart_rxd <= rxd_d;
            pw_valid <= head_v_d;
            pw_data <= head_d;
            tail_v_q <= tail_v_d;
            tail_q <= tail_d;
        end
    end
endmodule

// File: irs_endec_checker.sv
`timescale 1ns/1ps
module irs_chk import irs_pkg::*; #(
    parameter int PW_W = 8
) (
    input wire logic aclk, // Clock
    input wire logic aresetn, // Reset
    input wire logic baud_tick, // Tick
    input wire logic uart_rxd, // Rx out
    input wire logic infrared_transmit_out, // Ir out
    input wire logic pw_valid, // Word valid
    input wire logic [PW_W-1:0] pw_data, // Word
    input wire logic pw_ready, // Word taken
    input wire logic s_axi_awvalid, // Aw
    input wire logic s_axi_awready, // Aw
    input wire logic s_axi_wvalid, // W
    input wire logic s_axi_wready, // W
    input wire logic [1:0] s_axi_bresp, // B
    input wire logic s_axi_bvalid, // B
    input wire logic s_axi_bready, // B
    input wire logic [11:0] s_axi_araddr, // Ar
    input wire logic s_axi_arvalid, // Ar
    input wire logic s_axi_arready, // Ar
    input wire logic [31:0] s_axi_rdata, // R
    input wire logic s_axi_rvalid // R
);
    logic [11:0] ra_q, ra_d;
    logic [2:0] hc_q, hc_d;
    // Read address in flight, ticks seen during a light pulse
    always_comb begin
        ra_d = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : ra_q;
        hc_d = infrared_transmit_out ? hc_q + {2'h0, baud_tick} : 3'h0;
    end
    // Helper registers
    always_ff @(posedge aclk) begin
        ra_q <= aresetn ? ra_d : 12'h000;
        hc_q <= aresetn ? hc_d : 3'h0;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd;
        s_axi_arvalid && s_axi_arready;
    endsequence
    property p_rst;
        $rose(aresetn) |-> uart_rxd && !infrared_transmit_out && !pw_valid
            && !s_axi_bvalid && !s_axi_rvalid;
    endproperty
    a_rst: assert property (p_rst) else $error("not idle after reset");
    property p_wr;
        s_wr |-> ##2 s_axi_bvalid;
    endproperty
    a_wr: assert property (p_wr) else $error("write answer late");
    property p_rd;
        s_rd |=> s_axi_rvalid;
    endproperty
    a_rd: assert property (p_rd) else $error("read answer late");
    property p_bh;
        s_axi_bvalid && !s_axi_bready |=>
            s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bh: assert property (p_bh) else $error("write answer dropped");
    property p_rsv;
        s_axi_rvalid && ra_q == 12'h2fc |-> s_axi_rdata[31:8] == 24'h00_0000
            && !s_axi_rdata[3];
    endproperty
    a_rsv: assert property (p_rsv) else $error("unused bits not zero");
    property p_pw;
        pw_valid && !pw_ready |=> pw_valid && $stable(pw_data);
    endproperty
    a_pw: assert property (p_pw) else $error("width word lost");
    property p_txr;
        $rose(infrared_transmit_out) |-> $past(baud_tick);
    endproperty
    a_txr: assert property (p_txr) else $error("pulse off phase");
    property p_txw;
        $fell(infrared_transmit_out) |-> hc_q == 3'h3;
    endproperty
    a_txw: assert property (p_txw) else $error("pulse not 3 ticks");
endmodule
bind irs_endec irs_chk #(.PW_W(PW_W)) u_chk (
    .aclk(aclk),
    .aresetn(aresetn),
    .baud_tick(baud_tick),
    .uart_rxd(uart_rxd),
    .infrared_transmit_out(infrared_transmit_out),
    .pw_valid(pw_valid),
    .pw_data(pw_data),
    .pw_ready(pw_ready),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid)
);

// File: irs_far.sv
`timescale 1ns/1ps
module irs_far (
    input wire logic aclk, // System clock
    input wire logic tx_led, // Light from the block
    output logic rx_n // Receiver output
);
    logic echo = 1'h0; // Own light returns
    logic drv_n = 1'h1; // Remote light absent
    // Receiver goes low whenever light arrives
    assign rx_n = drv_n & ~(echo & tx_led);
    // Remote zero bit as one low pulse of w clocks
    task send(input int w);
        @(posedge aclk);
        drv_n <= 1'h0;
        repeat (w) @(posedge aclk);
        drv_n <= 1'h1;
    endtask
endmodule

// File: irs_tb.sv
`timescale 1ns/1ps
`include "irs_defs.svh"
module testbench;
    import irs_pkg::*;
    localparam logic [11:0] CA = {`IRS_CTL_IDX, 2'b00};
    localparam logic [11:0] SA = {`IRS_STAT_IDX, 2'b00};
    logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1, baud_tick = 1'h0;
    logic uart_txd = 1'h0, pw_ready = 1'h1;
    logic uart_rxd, infrared_receive_in, infrared_transmit_out, pw_valid;
    logic [7:0] pw_data;
    logic [7:0] dc[7] = '{8'h23, 8'h23, 8'h13, 8'h13,
        8'h03, 8'h21, 8'h22};
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hf, tc = 4'h0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, de[7] = '{0, 1, 0, 1, 1, 0, 0};
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, ovf;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    int n_mismatch = 0, total_checks = 0, seed = 61551, ctl_m, n;
    int dw[7] = '{10, 14, 6, 10, 1, 48, 48}, q[$];
    irs_endec uut (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .baud_tick(baud_tick),
        .uart_txd(uart_txd),
        .uart_rxd(uart_rxd),
        .infrared_receive_in(infrared_receive_in),
        .infrared_transmit_out(infrared_transmit_out),
        .pw_valid(pw_valid),
        .pw_data(pw_data),
        .pw_ready(pw_ready),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready)
    );
    // Only the two codec pins reach the transceiver model
    irs_far far (.aclk(aclk), .tx_led(infrared_transmit_out),
        .rx_n(infrared_receive_in));
    // Clock and a baud tick every 16 clocks
    initial forever #2 aclk = ~aclk;
    always @(posedge aclk) begin
        tc <= tc + 4'h1;
        baud_tick <= (tc == 4'hf);
    end
    task chk(input string s, input logic [31:0] g, e);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s exp %h got %h", s, e, g);
        end
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 0;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] re);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        s_axi_rready <= 0;
        chk("rdata", d, e);
        chk("rresp", {30'h0, s_axi_rresp}, {30'h0, re});
    endtask
    task setc(input logic [7:0] v);
        wr(CA, {24'h0, v});
        ctl_m = v & `IRS_CTL_MASK;
        chk("bresp", {30'h0, r}, 0);
    endtask
    task tk;
        do @(posedge aclk); while (!baud_tick);
    endtask
    task txbit(input logic b, input logic on);
        tk;
        repeat (2) @(posedge aclk);
        uart_txd <= b;
        for (int k = 1; k <= 16; k++) begin
            tk;
            @(posedge aclk);
            @(negedge aclk);
            chk("ir_tx", infrared_transmit_out,
                on && !b && k > 6 && k < 10);
        end
    endtask
    task rxchk(input logic e);
        int w;
        w = 0;
        n = 0;
        while (uart_rxd && w < 300) begin
            @(posedge aclk);
            w++;
        end
        while (!uart_rxd) begin
            @(posedge aclk);
            n += (baud_tick && !uart_rxd) ? 1 : 0;
        end
        chk("rx_ticks", n, e ? 16 : 0);
    endtask
    task dec(input logic [7:0] v, input int w, input logic e);
        setc(v);
        tk;
        repeat (8) @(posedge aclk);
        fork
            far.send(w);
            rxchk(e);
        join
    endtask
    task lb(input logic [7:0] v);
        setc(v);
        tk;
        fork
            begin
                uart_txd <= 0;
                repeat (12) tk;
                uart_txd <= 1;
            end
            rxchk(1);
        join
    endtask
    // Main sequence
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        uart_txd <= 1;
        rd(CA, 0, `IRS_RESP_OKAY);
        rd(12'h004, 0, `IRS_RESP_SLVERR);
        wr(12'h008, 32'hffff_ffff);
        chk("bresp", {30'h0, r}, `IRS_RESP_SLVERR);
        repeat (3) begin
            setc(8'($random(seed)));
            rd(CA, ctl_m, `IRS_RESP_OKAY);
        end
        $display("test regs done");
        setc(8'h01);
        txbit(0, 1);
        txbit(1, 1);
        setc(8'h00);
        txbit(0, 0);
        txbit(1, 0);
        $display("test encoder done");
        dw[0] = 1 + {$random(seed)} % 10;
        foreach (dc[i]) dec(dc[i], dw[i], de[i]);
        $display("test decoder done");
        lb(8'h17);
        far.echo <= 1;
        lb(8'h13);
        far.echo <= 0;
        $display("test loopback done");
        pw_ready <= 0;
        ovf = 0;
        for (int i = 0; i < 3; i++) begin
            dec(8'h23, 48, 1);
            // Whole divider periods (12 clocks) after the first low edge
            if (q.size() < 2) q.push_back((48 - 1) / (4 * 2 + 4));
            else ovf = 1;
        end
        chk("pw_valid", pw_valid, 1);
        // Idle status: receive high, transmit low, latched bit one
        rd(SA, {28'h000_0000, ovf, 3'b101}, `IRS_RESP_OKAY);
        chk("ovf", d[3], ovf);
        pw_ready <= 1;
        repeat (8) begin
            @(posedge aclk);
            if (pw_valid && pw_ready) begin
                chk("pw_data", pw_data, q.pop_front());
            end
        end
        chk("words", q.size(), 0);
        wr(SA, 32'h0000_0008);
        rd(SA, 32'h0000_0005, `IRS_RESP_OKAY);
        chk("ovf_clr", d[3], 0);
        $display("test buffer done");
        stop_test;
    end
    // Watchdog
    initial begin
        repeat (40000) @(posedge aclk);
        n_mismatch++;
        stop_test;
    end
endmodule
